// ===== pkg/knock_regs.vh
// Purpose: offsets, field positions, reset values and constants of the knock package control
// Assumes: word-wide registers, eight-bit word address
// Notes: definitions only
`ifndef KNOCK_REGS_VH
`define KNOCK_REGS_VH

// ----------------------------------------
// global register offsets
// ----------------------------------------
`define KPC_CTRL 8'h00
`define KPC_SERVED 8'h01
`define KPC_REFPHASE 8'h02
`define KPC_QUIETAMP 8'h03
`define KPC_NOISE 8'h04
`define KPC_COMMONSEQ 8'h05
`define KPC_STATUS 8'h06
// per-cylinder block: base + cylinder*8 + field
`define KPC_CYL_BASE 8'h10
`define KPC_CYL_LAST 8'h6F
`define KPC_F_CFG 3'h0
`define KPC_F_LIKE 3'h1
`define KPC_F_KAMP 3'h2
`define KPC_F_SHIFT 3'h3
`define KPC_F_BASE 3'h4
`define KPC_F_SEQ 3'h5
`define KPC_F_MAP 3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define KPC_CTRL_ONESHOT 0
`define KPC_CTRL_TRIG 1
`define KPC_CFG_PERMIT 0
`define KPC_CFG_SEQMODE 1
`define KPC_CFG_INDIV 2

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define KPC_SERVED_RST 4'hC
`define KPC_PERMIT_RST 1'b1
`define KPC_CYCLE_DEG 12'h2D0
`define KPC_LFSR_SEED 16'hACE1
`define KPC_LFSR_TAPS 16'hB400
`define KPC_MAP_HALF 8'h80

`endif

// ===== logic/knock_lfsr.v
// Purpose: free-running pseudo-random source
// Assumes: one draw per clock
// Notes: galois form, never reaches the all-zero state
`timescale 1ns/100ps
`default_nettype none
`include "knock_regs.vh"

module knock_lfsr (
	input wire clk,
	input wire resetn,
	output reg [15:0] rnd_q
);

	// ----------------------------------------
	// shift register
	// ----------------------------------------
	// advance every clock so draws are spread over time
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rnd_q <= `KPC_LFSR_SEED;
		end else if (rnd_q[0]) begin
			rnd_q <= (rnd_q >> 1) ^ `KPC_LFSR_TAPS;
		end else begin
			rnd_q <= rnd_q >> 1;
		end
	end

endmodule // knock_lfsr
`default_nettype wire

// ===== logic/start_angle_calc.v
// Purpose: package start angle of one cylinder, folded into one engine cycle
// Assumes: reference and base below one cycle, shift within +-127
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "knock_regs.vh"

module start_angle_calc (
	input wire [9:0] refPhase,
	input wire [9:0] baseAngle,
	input wire [7:0] angleShift,
	output reg [9:0] startAngle
);

	reg signed [12:0] sum; // -127 .. 1565

	// ----------------------------------------
	// sum and wrap
	// ----------------------------------------
	// (RULE_10) reference plus base plus shift
	always @* begin
		sum = $signed({3'h0, refPhase}) + $signed({3'h0, baseAngle}) + $signed({{5{angleShift[7]}}, angleShift});
		if (sum < 13'sh0000) begin
			sum = sum + $signed({1'b0, `KPC_CYCLE_DEG});
		// two cycles still fit thirteen bits with a clear sign bit
		end else if (sum >= $signed({`KPC_CYCLE_DEG, 1'b0})) begin
			sum = sum - $signed({`KPC_CYCLE_DEG, 1'b0});
		end else if (sum >= $signed({1'b0, `KPC_CYCLE_DEG})) begin
			sum = sum - $signed({1'b0, `KPC_CYCLE_DEG});
		end
		startAngle = sum[9:0];
	end

endmodule // start_angle_calc
`default_nettype wire

// ===== logic/knock_package_control.v
// Purpose: decides per combustion event whether a knocking or quiet package is emitted
// Assumes: crank angle input in degrees 0..719, each value held at least 12 clocks
// Notes: one cylinder is examined per clock in round robin
//
// Contract
// (RULE_01) permit bit 0 allows knocking, 1 forbids
// (RULE_02) likelihood used only in probability mode
// (RULE_03) rising trigger edge starts sequence playback
// (RULE_04) retrigger aborts and restarts sequence
// (RULE_05) noise level sets random amplitude spread
// (RULE_06) noise applies to every package
// (RULE_07) quiet events emit quiet amplitude packages
// (RULE_08) knocking events use per-cylinder amplitude
// (RULE_09) signed eight-bit shift, one degree steps
// (RULE_10) start angle is reference+base+shift
// (RULE_11) only served cylinders are processed
// (RULE_12) trigger mode continuous or single shot
// (RULE_13) knock decided by probability or sequence
// (RULE_14) route to outputs with map above half
// (RULE_15) fresh random draw below likelihood knocks
// (RULE_16) changes act at next decision only
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "knock_regs.vh"

module knock_package_control #(
	parameter NCYL = 12,
	parameter SEQ_LEN = 16,
	parameter POS_W = 4
) (
	input wire clk,
	input wire resetn,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wrStrobe,
	input wire rdStrobe,
	output reg [31:0] rdata_q,
	input wire [9:0] crankAngle,
	output reg pkgStart_q,
	output reg pkgKnock_q,
	output reg [15:0] pkgAmplitude_q,
	output reg [3:0] pkgSensorMask_q,
	output reg [3:0] pkgCylinder_q,
	output reg [9:0] pkgAngle_q,
	output reg seqActive_q
);

	// ----------------------------------------
	// noise function
	// ----------------------------------------
	// base +- noise*rnd/65536, clipped to the unsigned range
	function [15:0] applyNoise;
		input [15:0] base;
		input [15:0] noise;
		input [15:0] rnd;
		input up;
		reg [31:0] prod;
		reg [16:0] tmp;
		begin
			prod = noise * rnd;
			if (up) begin
				tmp = {1'b0, base} + {1'b0, prod[31:16]};
				applyNoise = tmp[16] ? 16'hFFFF : tmp[15:0];
			end else begin
				tmp = {1'b0, base} - {1'b0, prod[31:16]};
				applyNoise = tmp[16] ? 16'h0000 : tmp[15:0];
			end
		end
	endfunction

	// ----------------------------------------
	// global settings
	// ----------------------------------------
	reg oneShot_q; // trigger mode, 1 single shot
	reg trigLevel_q; // software-written trigger level
	reg trigPrev_q; // level one clock earlier
	reg [3:0] served_q; // number of served cylinders
	reg [9:0] refPhase_q; // reference phase in degrees
	reg [15:0] quietAmp_q; // amplitude without knocking
	reg [15:0] noise_q; // amplitude noise level
	reg [SEQ_LEN-1:0] commonSeq_q; // shared sequence table

	// ----------------------------------------
	// per-cylinder settings
	// ----------------------------------------
	reg [NCYL-1:0] permit_q; // 0 allows knocking
	reg [NCYL-1:0] seqMode_q; // 1 sequence mode, 0 probability
	reg [NCYL-1:0] indiv_q; // 1 own table, 0 common table
	reg [15:0] like_q [0:NCYL-1]; // knock likelihood
	reg [15:0] kamp_q [0:NCYL-1]; // knocking amplitude
	reg [7:0] shift_q [0:NCYL-1]; // signed start angle shift
	reg [9:0] base_q [0:NCYL-1]; // base angle
	reg [SEQ_LEN-1:0] seq_q [0:NCYL-1]; // individual table
	reg [3:0] map_q [0:NCYL-1]; // output routing bits

	// ----------------------------------------
	// runtime state
	// ----------------------------------------
	reg [3:0] scanIdx_q; // cylinder under examination
	reg [NCYL-1:0] armed_q; // event may fire for cylinder
	reg [9:0] prevAngle_q; // crank angle one clock earlier
	reg [POS_W-1:0] seqPos_q; // current sequence step
	reg [3:0] lastCyl_q; // status copy of last cylinder
	wire [15:0] rnd;
	wire [9:0] startAngle;

	// decoded bus access
	wire cylHit = (addr >= `KPC_CYL_BASE) && (addr <= `KPC_CYL_LAST);
	wire [4:0] cylSlot = addr[7:3] - 5'h02;
	wire [3:0] cylSel = cylSlot[3:0];
	wire [2:0] field = addr[2:0];

	// event conditions
	wire trigEdge = trigLevel_q & ~trigPrev_q;
	wire cycleWrap = crankAngle < prevAngle_q;
	wire angleMatch = crankAngle == startAngle;
	// (RULE_11) ignore cylinders past the served count
	wire inService = scanIdx_q < served_q;
	wire fire = inService && armed_q[scanIdx_q] && angleMatch;

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	knock_lfsr uRandom (
		.clk(clk),
		.resetn(resetn),
		.rnd_q(rnd)
	);

	// (RULE_09) shift taken as signed whole degrees
	start_angle_calc uAngle (
		.refPhase(refPhase_q),
		.baseAngle(base_q[scanIdx_q]),
		.angleShift(shift_q[scanIdx_q]),
		.startAngle(startAngle)
	);

	// ----------------------------------------
	// decision logic
	// ----------------------------------------
	reg [SEQ_LEN-1:0] seqTable;
	reg seqHit;
	reg wantKnock;
	reg isKnock;
	reg [15:0] baseAmp;
	always @* begin
		seqTable = indiv_q[scanIdx_q] ? seq_q[scanIdx_q] : commonSeq_q;
		seqHit = seqActive_q && seqTable[seqPos_q];
		// (RULE_13) mode picks decision source
		if (seqMode_q[scanIdx_q]) begin
			wantKnock = seqHit;
		end else begin
			// (RULE_02) likelihood read only here
			// (RULE_15) draw below likelihood
			wantKnock = rnd < like_q[scanIdx_q];
		end
		// (RULE_01) permit gate
		isKnock = wantKnock && !permit_q[scanIdx_q];
		// (RULE_07) quiet amplitude otherwise
		// (RULE_08) cylinder knock amplitude
		baseAmp = isKnock ? kamp_q[scanIdx_q] : quietAmp_q;
	end

	// ----------------------------------------
	// package output and scan
	// ----------------------------------------
	// package outputs except pkgStart_q are latched only when an event fires, so a package in flight keeps its values
	integer i;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scanIdx_q <= 4'h0;
			armed_q <= {NCYL{1'b0}};
			prevAngle_q <= 10'h000;
			pkgStart_q <= 1'b0;
			pkgKnock_q <= 1'b0;
			pkgAmplitude_q <= 16'h0000;
			pkgSensorMask_q <= 4'h0;
			pkgCylinder_q <= 4'h0;
			pkgAngle_q <= 10'h000;
			lastCyl_q <= 4'h0;
		end else begin
			prevAngle_q <= crankAngle;
			pkgStart_q <= 1'b0;
			// round robin over the served cylinders
			if (scanIdx_q + 4'h1 >= served_q) begin
				scanIdx_q <= 4'h0;
			end else begin
				scanIdx_q <= scanIdx_q + 4'h1;
			end
			// rearm once the angle has moved away
			if (!angleMatch) begin
				armed_q[scanIdx_q] <= 1'b1;
			end
			// (RULE_16) new settings taken at the decision
			if (fire) begin
				armed_q[scanIdx_q] <= 1'b0;
				pkgStart_q <= 1'b1;
				pkgKnock_q <= isKnock;
				// (RULE_05) spread scaled by noise
				// (RULE_06) every package gets noise
				pkgAmplitude_q <= applyNoise(baseAmp, noise_q, {rnd[7:0], rnd[15:8]}, rnd[3]);
				// (RULE_14) map entries above half
				pkgSensorMask_q <= map_q[scanIdx_q];
				pkgCylinder_q <= scanIdx_q;
				pkgAngle_q <= startAngle;
				lastCyl_q <= scanIdx_q;
			end
		end
	end

	// ----------------------------------------
	// sequence playback
	// ----------------------------------------
	// steps advance at the end of each engine cycle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trigPrev_q <= 1'b0;
			seqActive_q <= 1'b0;
			seqPos_q <= {POS_W{1'b0}};
		end else begin
			trigPrev_q <= trigLevel_q;
			if (trigEdge) begin
				// (RULE_03) rising edge starts playback
				// (RULE_04) restart from the first step
				seqActive_q <= 1'b1;
				seqPos_q <= {POS_W{1'b0}};
			end else if (seqActive_q && cycleWrap) begin
				if (seqPos_q == SEQ_LEN[POS_W-1:0] - 1'b1) begin
					seqPos_q <= {POS_W{1'b0}};
					// (RULE_12) single shot stops at the end
					seqActive_q <= !oneShot_q;
				end else begin
					seqPos_q <= seqPos_q + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			oneShot_q <= 1'b0;
			trigLevel_q <= 1'b0;
			served_q <= `KPC_SERVED_RST;
			refPhase_q <= 10'h000;
			quietAmp_q <= 16'h0000;
			noise_q <= 16'h0000;
			commonSeq_q <= {SEQ_LEN{1'b0}};
			permit_q <= {NCYL{`KPC_PERMIT_RST}};
			seqMode_q <= {NCYL{1'b0}};
			indiv_q <= {NCYL{1'b0}};
			for (i = 0; i < NCYL; i = i + 1) begin
				like_q[i] <= 16'h0000;
				kamp_q[i] <= 16'h0000;
				shift_q[i] <= 8'h00;
				base_q[i] <= 10'h000;
				seq_q[i] <= {SEQ_LEN{1'b0}};
				map_q[i] <= 4'h0;
			end
		end else if (wrStrobe) begin
			if (cylHit && cylSel < NCYL) begin
				// per-cylinder block
				case (field)
					`KPC_F_CFG: begin
						permit_q[cylSel] <= wdata[`KPC_CFG_PERMIT];
						seqMode_q[cylSel] <= wdata[`KPC_CFG_SEQMODE];
						indiv_q[cylSel] <= wdata[`KPC_CFG_INDIV];
					end
					`KPC_F_LIKE: like_q[cylSel] <= wdata[15:0];
					`KPC_F_KAMP: kamp_q[cylSel] <= wdata[15:0];
					`KPC_F_SHIFT: begin
						// -128 is outside the range, clip to -127
						shift_q[cylSel] <= (wdata[7:0] == 8'h80) ? 8'h81 : wdata[7:0];
					end
					`KPC_F_BASE: begin
						base_q[cylSel] <= (wdata[9:0] >= `KPC_CYCLE_DEG) ? 10'h000 : wdata[9:0];
					end
					`KPC_F_SEQ: seq_q[cylSel] <= wdata[SEQ_LEN-1:0];
					`KPC_F_MAP: begin
						// (RULE_14) keep only the above-half decision
						map_q[cylSel] <= {wdata[31:24] > `KPC_MAP_HALF, wdata[23:16] > `KPC_MAP_HALF,
							wdata[15:8] > `KPC_MAP_HALF, wdata[7:0] > `KPC_MAP_HALF};
					end
					default: begin
						// unused field, write ignored
					end
				endcase
			end else begin
				case (addr)
					`KPC_CTRL: begin
						oneShot_q <= wdata[`KPC_CTRL_ONESHOT];
						trigLevel_q <= wdata[`KPC_CTRL_TRIG];
					end
					`KPC_SERVED: begin
						// counts above the cylinder total are clipped
						served_q <= (wdata[3:0] > NCYL) ? NCYL[3:0] : wdata[3:0];
					end
					`KPC_REFPHASE: begin
						refPhase_q <= (wdata[9:0] >= `KPC_CYCLE_DEG) ? 10'h000 : wdata[9:0];
					end
					`KPC_QUIETAMP: quietAmp_q <= wdata[15:0];
					`KPC_NOISE: noise_q <= wdata[15:0];
					`KPC_COMMONSEQ: commonSeq_q <= wdata[SEQ_LEN-1:0];
					default: begin
						// unmapped or read-only, ignored
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	// data valid the cycle after the strobe, zero otherwise
	reg [31:0] rdMux;
	always @* begin
		rdMux = 32'h00000000;
		if (cylHit && cylSel < NCYL) begin
			case (field)
				`KPC_F_CFG: rdMux = {29'h0, indiv_q[cylSel], seqMode_q[cylSel], permit_q[cylSel]};
				`KPC_F_LIKE: rdMux = {16'h0, like_q[cylSel]};
				`KPC_F_KAMP: rdMux = {16'h0, kamp_q[cylSel]};
				`KPC_F_SHIFT: rdMux = {{24{shift_q[cylSel][7]}}, shift_q[cylSel]};
				`KPC_F_BASE: rdMux = {22'h0, base_q[cylSel]};
				`KPC_F_SEQ: rdMux = {{(32-SEQ_LEN){1'b0}}, seq_q[cylSel]};
				`KPC_F_MAP: rdMux = {map_q[cylSel][3], 7'h0, map_q[cylSel][2], 7'h0,
					map_q[cylSel][1], 7'h0, map_q[cylSel][0], 7'h0};
				default: rdMux = 32'h00000000;
			endcase
		end else begin
			case (addr)
				`KPC_CTRL: rdMux = {30'h0, trigLevel_q, oneShot_q};
				`KPC_SERVED: rdMux = {28'h0, served_q};
				`KPC_REFPHASE: rdMux = {22'h0, refPhase_q};
				`KPC_QUIETAMP: rdMux = {16'h0, quietAmp_q};
				`KPC_NOISE: rdMux = {16'h0, noise_q};
				`KPC_COMMONSEQ: rdMux = {{(32-SEQ_LEN){1'b0}}, commonSeq_q};
				`KPC_STATUS: rdMux = {20'h0, lastCyl_q, 3'h0, seqActive_q, {(4-POS_W){1'b0}}, seqPos_q};
				default: rdMux = 32'h00000000;
			endcase
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 32'h00000000;
		end else if (rdStrobe) begin
			rdata_q <= rdMux;
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

endmodule // knock_package_control
`default_nettype wire

// ===== tb/crank_model.sv
// Purpose: crank angle source standing in for the engine model
// Assumes: one degree per HOLD clocks
// Notes: wraps 719 to 0 like a four-stroke cycle
`timescale 1ns/100ps
`default_nettype none
module crank_model #(parameter int HOLD = 12) (
	input wire logic clk,
	input wire logic resetn,
	output logic [9:0] crankAngle
);
	logic [4:0] tick_q; // clocks spent on this degree
	logic [9:0] angle_q; // current degree
	assign crankAngle = angle_q;
	// advance one degree, hold long enough for a full scan
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_q <= 5'h00;
			angle_q <= 10'h000;
		end else if (tick_q == 5'(HOLD - 1)) begin
			tick_q <= 5'h00;
			angle_q <= (angle_q == 10'h2CF) ? 10'h000 : angle_q + 10'h001;
		end else begin
			tick_q <= tick_q + 5'h01;
		end
	end
endmodule // crank_model
`default_nettype wire

// ===== tb/knock_package_control_asserts.sv
// Purpose: port-level checks of the package control
// Assumes: single clock domain
// Notes: attached by bind
`timescale 1ns/100ps
`default_nettype none
module knock_package_control_asserts #(parameter NCYL = 12, parameter SEQ_LEN = 16, parameter POS_W = 4) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [31:0] rdata_q,
	input wire logic [9:0] crankAngle,
	input wire logic pkgStart_q,
	input wire logic pkgKnock_q,
	input wire logic [15:0] pkgAmplitude_q,
	input wire logic [3:0] pkgSensorMask_q,
	input wire logic [3:0] pkgCylinder_q,
	input wire logic [9:0] pkgAngle_q,
	input wire logic seqActive_q
);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	read_idle_zero_a: assert property (!$past(rdStrobe) |-> rdata_q == 32'h0)
		else $error("read data not zero outside read slot");
	unmapped_read_a: assert property (rdStrobe && addr > 8'h6F |=> rdata_q == 32'h0)
		else $error("unmapped read returned data");
	knock_flag_hold_a: assert property (!pkgStart_q |-> $stable(pkgKnock_q))
		else $error("knock flag changed between packages");
	amplitude_hold_a: assert property (!pkgStart_q |-> $stable(pkgAmplitude_q))
		else $error("amplitude changed between packages");
	sensor_mask_hold_a: assert property (!pkgStart_q |-> $stable(pkgSensorMask_q))
		else $error("sensor mask changed between packages");
	start_angle_match_a: assert property (pkgStart_q |-> pkgAngle_q == $past(crankAngle))
		else $error("package angle differs from crank angle");
	angle_in_cycle_a: assert property (pkgStart_q |-> pkgAngle_q < 10'h2D0)
		else $error("package angle beyond one engine cycle");
	cylinder_range_a: assert property (pkgStart_q |-> pkgCylinder_q < 4'hC)
		else $error("package from cylinder outside range");
	// main scenarios reached
	knock_pkg_c: cover property (pkgStart_q && pkgKnock_q);
	quiet_pkg_c: cover property (pkgStart_q && !pkgKnock_q);
	seq_run_c: cover property ($rose(seqActive_q));
	seq_end_c: cover property ($fell(seqActive_q));
endmodule // knock_package_control_asserts
bind knock_package_control knock_package_control_asserts #(.NCYL(NCYL), .SEQ_LEN(SEQ_LEN), .POS_W(POS_W)) u_chk (
	.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
	.rdata_q(rdata_q), .crankAngle(crankAngle), .pkgStart_q(pkgStart_q), .pkgKnock_q(pkgKnock_q),
	.pkgAmplitude_q(pkgAmplitude_q), .pkgSensorMask_q(pkgSensorMask_q), .pkgCylinder_q(pkgCylinder_q),
	.pkgAngle_q(pkgAngle_q), .seqActive_q(seqActive_q));
`default_nettype wire

// ===== tb/knock_package_control_tb_top.sv
// Purpose: register-driven tests of the package control
// Assumes: cylinder 11 is the one under test, its start angle 75
// Notes: other cylinders fire at 700 and are ignored
`timescale 1ns/100ps
`default_nettype none
module knock_package_control_tb_top;
	logic clk = 1'b0; // 40 MHz
	logic resetn = 1'b0; // active low
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wrStrobe = 1'b0;
	logic rdStrobe = 1'b0;
	logic [31:0] rdata_q;
	logic [9:0] crankAngle;
	logic pkgStart_q, pkgKnock_q, seqActive_q;
	logic [15:0] pkgAmplitude_q;
	logic [3:0] pkgSensorMask_q, pkgCylinder_q;
	logic [9:0] pkgAngle_q;
	int miscompares = 0;
	int tests_run = 0;
	bit seen;
	always #12.5 clk = ~clk;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	crank_model i_crank_model (.clk(clk), .resetn(resetn), .crankAngle(crankAngle));
	// short tables so that a single shot run ends inside the cycle budget
	knock_package_control #(.SEQ_LEN(4), .POS_W(2)) i_knock_package_control (.clk(clk), .resetn(resetn),
		.addr(addr), .wdata(wdata),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata_q(rdata_q), .crankAngle(crankAngle),
		.pkgStart_q(pkgStart_q), .pkgKnock_q(pkgKnock_q), .pkgAmplitude_q(pkgAmplitude_q),
		.pkgSensorMask_q(pkgSensorMask_q), .pkgCylinder_q(pkgCylinder_q), .pkgAngle_q(pkgAngle_q),
		.seqActive_q(seqActive_q));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task final_report;
		$display("compares %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
	endtask
	// data stands only in the slot after the read edge
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		chk(rdata_q, e);
	endtask
	// bounded wait, a little over one engine cycle
	task waitPkg(output bit s);
		s = 0;
		for (int n = 0; n < 9000 && !s; n++) begin
			@(posedge clk);
			#1;
			if (pkgStart_q === 1'b1 && pkgCylinder_q === 4'hB)
				s = 1;
		end
	endtask
	task pkg(input logic k, input logic [15:0] a);
		bit s;
		waitPkg(s);
		chk(s, 1);
		chk(pkgKnock_q, k);
		chk(pkgAmplitude_q, a);
		chk(pkgAngle_q, 10'h04B);
		chk(pkgSensorMask_q, 4'h2);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h01, 32'hC);
		rd(8'h68, 32'h1);
		rd(8'h70, 32'h0);
		// start of cylinder 11: 700+100-5 folds to 75
		wr(8'h02, 32'h2BC);
		wr(8'h6C, 32'h64);
		wr(8'h6B, 32'hFB);
		// lane 0 at exactly half is not routed
		wr(8'h6E, 32'h8180);
		rd(8'h6E, 32'h8000);
		wr(8'h03, 32'h1234);
		wr(8'h69, 32'hFFFF);
		wr(8'h6A, 32'h8000);
		pkg(1'b0, 16'h1234);
		wr(8'h68, 32'h0);
		pkg(1'b1, 16'h8000);
		// zero likelihood with noise: quiet, spread bounded
		wr(8'h69, 32'h0);
		wr(8'h03, 32'h4000);
		wr(8'h04, 32'h1000);
		waitPkg(seen);
		chk(seen, 1);
		chk(pkgKnock_q, 0);
		chk(pkgAmplitude_q >= 16'h3000 && pkgAmplitude_q <= 16'h5000, 1);
		// common table knocks at step 1 only
		wr(8'h04, 32'h0);
		wr(8'h03, 32'h1234);
		wr(8'h05, 32'h2);
		wr(8'h68, 32'h2);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h2);
		repeat (4) @(posedge clk);
		chk(seqActive_q, 1);
		// status: last cylinder 11, playing, step 0
		rd(8'h06, 32'h00000B10);
		pkg(1'b1, 16'h8000);
		pkg(1'b0, 16'h1234);
		// restart puts playback back to step 1 after the wrap
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h2);
		pkg(1'b1, 16'h8000);
		// single shot from here, level stays high so no new edge
		wr(8'h00, 32'h3);
		// own table knocks at step 2 only
		wr(8'h6D, 32'h4);
		wr(8'h68, 32'h6);
		pkg(1'b1, 16'h8000);
		pkg(1'b0, 16'h1234);
		// the wait spans the wrap that ends the single shot run
		wr(8'h01, 32'hB);
		waitPkg(seen);
		chk(seen, 0);
		chk(seqActive_q, 0);
		final_report;
	end
	// hang guard, ahead of the cycle budget
	initial begin
		repeat (95000) @(posedge clk);
		miscompares++;
		final_report;
	end
endmodule // knock_package_control_tb_top
`default_nettype wire
